/* hdl/bms_regs.svh */
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
// mode codes from the three-level decoder
`define BMS_MODE_CODE_FPWM 2'h0
`define BMS_MODE_CODE_MONO 2'h1
`define BMS_MODE_CODE_SKIP 2'h3
// cycles of the switching clock, apart from the ramp step count
`define BMS_HANDOVER_CYCLES 4096
`define BMS_RAMP_CYCLES 128
`define BMS_RAMP_STEPS 4
`define BMS_IDLE_CYCLES 8
`define BMS_REFRESH_CYCLES 1
// sink threshold step codes, full scale is the 7A limit
`define BMS_SINK_STEP_FULL 2'h3
`endif

/* hdl/bms_pkg.sv */
package bms_pkg;
   typedef enum logic [4:0] {
      BMS_ST_OFF   = 5'h01,
      BMS_ST_MONO  = 5'h02,
      BMS_ST_WAIT  = 5'h04,
      BMS_ST_FPWM  = 5'h08,
      BMS_ST_SKIP  = 5'h10
   } bms_state_t;
   typedef enum logic [2:0] {
      BMS_PH_IDLE = 3'h1,
      BMS_PH_LOW  = 3'h2,
      BMS_PH_HIGH = 3'h4
   } bms_phase_t;
endpackage

/* hdl/bms_ramp_if.sv */
`timescale 1ns/100ps
interface bms_ramp_if;
   logic start;
   logic [1:0] step;
   logic done;
   modport ctrl (output start, input step, input done);
   modport ramp (input start, output step, output done);
endinterface

/* hdl/bms_sink_ramp.sv */
`timescale 1ns/100ps
`include "bms_regs.svh"
module bms_sink_ramp #(
   parameter int RAMP_CYCLES = `BMS_RAMP_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control side
   bms_ramp_if.ramp rp
);
   localparam int CW = $clog2(RAMP_CYCLES + 1);
   localparam int STEP_LEN = RAMP_CYCLES / `BMS_RAMP_STEPS;
   logic [CW-1:0] cnt_q, cnt_d;
   logic run_q, run_d;
   logic [1:0] step_q, step_d;
   // ==========================================================
   // four-step sink threshold over the ramp window
   always_comb begin
      cnt_d = cnt_q;
      run_d = run_q;
      step_d = step_q;
      if (!rp.start) begin
         cnt_d = '0;
         run_d = 1'b0;
         step_d = 2'h0;
      end else if (cnt_q != CW'(RAMP_CYCLES)) begin
         run_d = 1'b1;
         cnt_d = cnt_q + CW'(1);
         step_d = 2'((32'(cnt_q) + 1) / STEP_LEN > 3 ? 3 : (32'(cnt_q) + 1) / STEP_LEN); // see R05
      end else begin
         step_d = `BMS_SINK_STEP_FULL; // see R17
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         run_q <= 1'b0;
         step_q <= 2'h0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= run_d;
         step_q <= step_d;
      end
   end
   assign rp.step = step_q;
   assign rp.done = (cnt_q == CW'(RAMP_CYCLES));
endmodule

/* hdl/bms_sequencer.sv */
// Operation
// R01: floating or mid-supply mode selects monotonic startup
// R02: monotonic startup holds both switches off
// R03: switching starts when feedback crosses soft-start
// R04: first switching turns low side on first
// R05: sink threshold rises in four steps, 128 cycles
// R06: 4096 cycles after 92.5% feedback, go forced-PWM
// R07: skip light load switches on demand, never sinks
// R08: skip medium/heavy load keeps fixed frequency
// R09: high side idle over eight cycles, refresh pulse
// R10: skip turns low side off at 0.2A
// R11: high-side pulse lasts until 0.58A reached
// R12: skip at turn-on uses monotonic startup first
// R13: skip and forced-PWM may change any time
// R14: outside keeps soft-start at or below 2ms
// R15: grounded mode input selects forced-PWM
// R16: forced-PWM low side off at period end or 0.875A
// R17: sink threshold ends at full 7A limit
// R18: mode decoded two bits, comparator flags synchronous
`timescale 1ns/100ps
`include "bms_regs.svh"
module bms_sequencer #(
   parameter int HANDOVER_CYCLES = `BMS_HANDOVER_CYCLES,
   parameter int RAMP_CYCLES = `BMS_RAMP_CYCLES,
   parameter int IDLE_CYCLES = `BMS_IDLE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // mode and enable
   input wire logic enable,
   input wire logic [1:0] mode_code,
   // comparator flags, same clock
   input wire logic period_start,
   input wire logic pwm_demand,
   input wire logic fb_above_ss,
   input wire logic fb_above_pgood,
   input wire logic il_above_min_on,
   input wire logic il_sink_limit,
   input wire logic il_below_zero_cut,
   // switch drive and status
   output logic hs_on,
   output logic ls_on,
   output logic [1:0] sink_step,
   output bms_pkg::bms_state_t state,
   output logic startup_done
);
   import bms_pkg::*;
   localparam int HW = $clog2(HANDOVER_CYCLES + 1);
   localparam int IW = $clog2(IDLE_CYCLES + 2);

   // ==========================================================
   // reset release
   logic rst_m_q, rst_n_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_m_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_n_q <= rst_m_q;
      end
   end

   // ==========================================================
   // sink threshold ramp
   bms_ramp_if rif();
   bms_sink_ramp #(.RAMP_CYCLES(RAMP_CYCLES)) u_ramp (
      .clk(clk),
      .rst_n(rst_n_q),
      .rp(rif.ramp)
   );

   // ==========================================================
   // mode sequencing
   bms_state_t st_q, st_d;
   logic [HW-1:0] hcnt_q, hcnt_d;
   logic switching_q, switching_d;
   logic skip_sel;
   assign skip_sel = (mode_code == `BMS_MODE_CODE_SKIP); // see R18

   always_comb begin
      st_d = st_q;
      hcnt_d = hcnt_q;
      switching_d = switching_q;
      case (st_q)
         BMS_ST_OFF: begin
            switching_d = 1'b0;
            hcnt_d = '0;
            if (enable) begin
               if (mode_code == `BMS_MODE_CODE_FPWM) begin
                  st_d = BMS_ST_FPWM; // see R15
                  switching_d = 1'b1;
               end else begin
                  st_d = BMS_ST_MONO; // see R01, R12
               end
            end
         end
         BMS_ST_MONO: begin
            if (fb_above_ss) begin
               switching_d = 1'b1; // see R03
               st_d = BMS_ST_WAIT;
            end
         end
         BMS_ST_WAIT: begin
            if (fb_above_pgood || hcnt_q != '0) begin
               hcnt_d = hcnt_q + HW'(1);
            end
            if (hcnt_q == HW'(HANDOVER_CYCLES - 1)) begin
               st_d = skip_sel ? BMS_ST_SKIP : BMS_ST_FPWM; // see R06, R12
            end
         end
         BMS_ST_FPWM: begin
            if (skip_sel) begin
               st_d = BMS_ST_SKIP; // see R13
            end
         end
         BMS_ST_SKIP: begin
            if (!skip_sel) begin
               st_d = BMS_ST_FPWM; // see R13
            end
         end
         default: st_d = BMS_ST_OFF;
      endcase
      if (!enable) begin
         st_d = BMS_ST_OFF;
         switching_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= BMS_ST_OFF;
         hcnt_q <= '0;
         switching_q <= 1'b0;
      end else begin
         st_q <= st_d;
         hcnt_q <= hcnt_d;
         switching_q <= switching_d;
      end
   end
   assign rif.start = switching_q; // see R05

   // ==========================================================
   // switch phase control
   bms_phase_t ph_q, ph_d;
   logic hs_q, hs_d, ls_q, ls_d;
   logic first_q, first_d;
   logic [IW-1:0] idle_q, idle_d;
   logic in_skip, in_fpwm;
   assign in_skip = (st_q == BMS_ST_SKIP);
   assign in_fpwm = (st_q == BMS_ST_FPWM) || (st_q == BMS_ST_WAIT);

   always_comb begin
      ph_d = ph_q;
      hs_d = 1'b0;
      ls_d = 1'b0;
      first_d = first_q;
      idle_d = idle_q;
      if (!switching_q || !(in_skip || in_fpwm)) begin
         ph_d = BMS_PH_IDLE; // see R02
         first_d = 1'b1;
         idle_d = '0;
      end else begin
         if (ph_q == BMS_PH_HIGH || hs_q) begin
            idle_d = '0;
         end else if (idle_q <= IW'(IDLE_CYCLES)) begin
            idle_d = idle_q + IW'(1);
         end
         case (ph_q)
            BMS_PH_IDLE: begin
               if (first_q) begin
                  ph_d = BMS_PH_LOW; // see R04
                  first_d = 1'b0;
               end else if (period_start && in_fpwm) begin
                  ph_d = BMS_PH_HIGH;
               end else if (period_start && in_skip && pwm_demand) begin
                  // refresh bootstrap when high side idled too long
                  if (idle_q > IW'(IDLE_CYCLES)) begin
                     ph_d = BMS_PH_LOW; // see R09
                  end else begin
                     ph_d = BMS_PH_HIGH; // see R07, R08
                  end
               end
            end
            BMS_PH_HIGH: begin
               hs_d = 1'b1;
               if (il_above_min_on && (!pwm_demand || period_start)) begin
                  ph_d = BMS_PH_LOW; // see R11, R16
                  hs_d = 1'b0;
               end
            end
            BMS_PH_LOW: begin
               ls_d = 1'b1;
               if (period_start || (in_fpwm && il_sink_limit)) begin
                  ls_d = 1'b0;
                  ph_d = in_fpwm ? BMS_PH_HIGH : BMS_PH_IDLE; // see R16
                  idle_d = '0;
               end else if (in_skip && il_below_zero_cut) begin
                  ls_d = 1'b0;
                  ph_d = BMS_PH_IDLE; // see R10, R07
                  if (idle_q > IW'(IDLE_CYCLES)) begin
                     ph_d = BMS_PH_HIGH; // see R09
                  end
               end
            end
            default: ph_d = BMS_PH_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ph_q <= BMS_PH_IDLE;
         hs_q <= 1'b0;
         ls_q <= 1'b0;
         first_q <= 1'b1;
         idle_q <= '0;
      end else begin
         ph_q <= ph_d;
         hs_q <= hs_d;
         ls_q <= ls_d;
         first_q <= first_d;
         idle_q <= idle_d;
      end
   end

   // ==========================================================
   // outputs
   assign hs_on = (ph_q == BMS_PH_HIGH);
   assign ls_on = (ph_q == BMS_PH_LOW);
   assign sink_step = rif.step;
   assign state = st_q;
   assign startup_done = in_skip || (st_q == BMS_ST_FPWM);
endmodule

/* verif/bms_seq_properties.sv */
`timescale 1ns/100ps
// ==========
// sequencer checker
module bms_seq_properties (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // mode and flags
   input wire logic enable,
   input wire logic [1:0] mode_code,
   input wire logic period_start,
   input wire logic il_above_min_on,
   input wire logic il_sink_limit,
   input wire logic il_below_zero_cut,
   // switch drive and status
   input wire logic hs_on,
   input wire logic ls_on,
   input wire logic [1:0] sink_step,
   input wire bms_pkg::bms_state_t state,
   input wire logic startup_done
);
   import bms_pkg::*;
   logic [3:0] idle_q;
   logic [3:0] idle_d;
   // cycles with both switches off
   always_comb idle_d = (hs_on || ls_on) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hF};
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) idle_q <= 4'h0;
      else idle_q <= idle_d;
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   property p_entry;
      state == BMS_ST_OFF && enable |=>
         state == (($past(mode_code) == 2'h0) ? BMS_ST_FPWM : BMS_ST_MONO);
   endproperty
   property p_mono_off;
      state == BMS_ST_MONO |-> !hs_on && !ls_on;
   endproperty
   property p_first_low;
      $rose(state == BMS_ST_WAIT) && enable |-> !hs_on ##1 ls_on;
   endproperty
   property p_zero_cut;
      state == BMS_ST_SKIP && mode_code == 2'h3 && enable && ls_on && il_below_zero_cut
         |=> !ls_on;
   endproperty
   property p_min_on;
      enable && startup_done && hs_on && !il_above_min_on |=> hs_on;
   endproperty
   property p_fpwm_low;
      state == BMS_ST_FPWM && mode_code != 2'h3 && enable && ls_on
         && (period_start || il_sink_limit) |=> hs_on;
   endproperty
   property p_refresh;
      state == BMS_ST_SKIP && $rose(hs_on) |-> $past(ls_on) || idle_q <= 4'h9;
   endproperty
   property p_step;
      sink_step != $past(sink_step) && state != BMS_ST_OFF
         |-> sink_step == $past(sink_step) + 2'h1;
   endproperty
   a_entry: assert property (p_entry) else $error("entry state wrong");
   a_mono_off: assert property (p_mono_off) else $error("switch on in mono");
   a_first_low: assert property (p_first_low) else $error("high side first");
   a_zero_cut: assert property (p_zero_cut) else $error("low side past cut");
   a_min_on: assert property (p_min_on) else $error("high pulse too short");
   a_fpwm_low: assert property (p_fpwm_low) else $error("low phase end wrong");
   a_refresh: assert property (p_refresh) else $error("no refresh pulse");
   a_step: assert property (p_step) else $error("sink step jump");
   c_refresh: cover property (state == BMS_ST_SKIP && idle_q > 4'h8 && ls_on);
   c_skip: cover property (state == BMS_ST_SKIP && $past(state) == BMS_ST_FPWM);
   c_full: cover property (sink_step == 2'h3);
endmodule

/* verif/bms_plant_model.sv */
`timescale 1ns/100ps
// ==========
// coil current and period model
module bms_plant_model #(
   parameter int PERIOD = 10
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // switch drive, current slope
   input wire logic hs_on,
   input wire logic ls_on,
   input wire logic [3:0] slope,
   // comparator flags
   output logic period_start,
   output logic il_above_min_on,
   output logic il_sink_limit,
   output logic il_below_zero_cut
);
   int il = 0;
   int cnt = 0;
   // current in units of 10 mA
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         il <= 0;
         cnt <= 0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         if (hs_on) il <= il + int'(slope) + 1;
         else if (ls_on) il <= il - int'(slope) - 1;
         else if (il != 0) il <= il - ((il > 0) ? 1 : -1);
      end
   end
   assign period_start = (cnt == 0);
   assign il_above_min_on = (il >= 58);
   assign il_sink_limit = (il <= -87);
   assign il_below_zero_cut = (il <= 20);
endmodule

/* verif/tb_top.sv */
`timescale 1ns/100ps
// ==========
// sequencer testbench
module tb_top;
   import bms_pkg::*;
   localparam int HO = 16;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic enable = 1'b0;
   logic [1:0] mode_code = 2'h0;
   logic [1:0] dmd_sel = 2'h0;
   logic pwm_demand = 1'b0;
   logic fb_above_ss = 1'b0;
   logic fb_above_pgood = 1'b0;
   logic [3:0] slope = 4'h1;
   logic period_start, il_above_min_on, il_sink_limit, il_below_zero_cut;
   logic hs_on, ls_on, startup_done;
   logic [1:0] sink_step;
   bms_state_t state;
   logic [31:0] seed = 32'h58;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   bms_sequencer #(.HANDOVER_CYCLES(HO), .RAMP_CYCLES(8), .IDLE_CYCLES(8)) DUT (.clk, .arst_n,
      .enable, .mode_code, .period_start, .pwm_demand, .fb_above_ss, .fb_above_pgood,
      .il_above_min_on, .il_sink_limit, .il_below_zero_cut, .hs_on, .ls_on, .sink_step,
      .state, .startup_done);
   bms_plant_model PM (.clk, .rst_n(arst_n), .hs_on, .ls_on, .slope, .period_start,
      .il_above_min_on, .il_sink_limit, .il_below_zero_cut);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic bms_state_t exp_st(logic [1:0] m, bit fin);
      if (m == 2'h3 && fin) return BMS_ST_SKIP;
      return (fin || m == 2'h0) ? BMS_ST_FPWM : BMS_ST_MONO;
   endfunction
   task automatic summarize();
      if (bad_count == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [4:0] e, logic [4:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // all testbench-driven inputs change 1 ns after the edge
   task automatic step(int n);
      repeat (n) begin
         @(posedge clk);
         #1;
         slope = 4'(rnd());
         pwm_demand = (dmd_sel == 2'h0) ? 1'(rnd()) : dmd_sel[1];
      end
   endtask
   task automatic run(logic [1:0] m);
      int k = 0;
      mode_code = m;
      enable = 1'b1;
      step(1);
      chk("entry", exp_st(m, 0), state);
      if (m != 2'h0) begin
         step(1 + rnd() % 6); // short soft-start
         chk("mono off", 5'h0, {3'h0, hs_on, ls_on});
         fb_above_ss = 1'b1;
         step(1);
         chk("wait", BMS_ST_WAIT, state);
         step(1);
         chk("first low", 5'h1, {3'h0, hs_on, ls_on});
         step(10);
         chk("ramp", 5'h3, sink_step);
         fb_above_pgood = 1'b1;
         while (state == BMS_ST_WAIT && k < 40) begin
            step(1);
            k++;
         end
         chk("handover", 5'h1, 5'(k >= HO && k <= HO + 1));
      end else begin
         step(12);
         chk("ramp", 5'h3, sink_step);
      end
      chk("final", exp_st(m, 1), state);
      chk("done", 5'h1, 5'(startup_done));
   endtask
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      step(20);
      arst_n = 1'b1;
      step(3);
      for (int m = 0; m < 4; m++) begin
         run(2'(m));
         step(30 + rnd() % 30);
         if (m == 3) begin
            dmd_sel = 2'h1;
            step(14);
            dmd_sel = 2'h2; // long idle, refresh first
            step(12);
            dmd_sel = 2'h0;
            mode_code = 2'h0;
            step(1);
            chk("to fpwm", BMS_ST_FPWM, state);
            mode_code = 2'h3;
            step(20);
            chk("to skip", BMS_ST_SKIP, state);
         end
         enable = 1'b0;
         fb_above_ss = 1'b0;
         fb_above_pgood = 1'b0;
         step(1);
         chk("off", BMS_ST_OFF, state);
         step(1);
         chk("off switches", 5'h0, {3'h0, hs_on, ls_on});
         step(1);
      end
      summarize();
   end
endmodule
bind bms_sequencer bms_seq_properties u_chk (.clk, .arst_n, .enable, .mode_code, .period_start,
   .il_above_min_on, .il_sink_limit, .il_below_zero_cut, .hs_on, .ls_on, .sink_step, .state,
   .startup_done);
